/* verilog/prx_regs.sv */
// rate, emitter current and result registers of the proximity sensor
// assumes: a serial bus engine outside issues one-cycle read/write strobes
// on an 8-bit register address, synchronous to clk
`timescale 1ns/1ps
`include "prx_map.svh"

module prx_regs #(
    parameter int unsigned CLK_HZ    = `PRX_CLK_HZ, // shrink in simulation
    parameter logic [1:0]  CAL_TAG   = `PRX_CAL_TAG // value arbitrary
) (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        selftimed_en,
    input  wire logic        meas_valid,
    input  wire logic [15:0] meas_result,
    output prx_pkg::prx_rate_t applied_rate,
    output logic             meas_tick,
    output logic      [5:0]  led_current_code
);

    // ==========================================
    // state
    logic [2:0]  rate_written;   // value software last wrote
    logic [15:0] result;         // last completed measurement
    logic [7:0]  low_shadow;     // low byte frozen at high-byte read
    logic        shadow_armed;   // next low read uses the shadow
    logic [31:0] tick_cnt;       // cycles left in current period

    // ==========================================
    // decode
    wire         wr_rate    = reg_wr && (reg_addr == `PRX_OFS_RATE);
    wire         wr_cur     = reg_wr && (reg_addr == `PRX_OFS_CURRENT);
    wire         rd_high    = reg_rd && (reg_addr == `PRX_OFS_RES_HIGH);
    wire         rd_low     = reg_rd && (reg_addr == `PRX_OFS_RES_LOW);
    wire  [5:0]  cur_in     = reg_wdata[`PRX_CUR_MSB:0];
    // saturate rather than reject, so a bad code never overdrives the emitter
    wire  [5:0]  cur_sat    = (cur_in > `PRX_CUR_MAX) ? `PRX_CUR_MAX : cur_in;
    wire  [7:0]  low_byte   = shadow_armed ? low_shadow : result[7:0];

    // period in clock cycles for a rate code
    function automatic logic [31:0] period_of(input logic [2:0] code);
        logic [63:0] uhz;
        uhz = `PRX_RATE_0_UHZ;
        case (code)
            3'h0: uhz = `PRX_RATE_0_UHZ;
            3'h1: uhz = `PRX_RATE_1_UHZ;
            3'h2: uhz = `PRX_RATE_2_UHZ;
            3'h3: uhz = `PRX_RATE_3_UHZ;
            3'h4: uhz = `PRX_RATE_4_UHZ;
            3'h5: uhz = `PRX_RATE_5_UHZ;
            3'h6: uhz = `PRX_RATE_6_UHZ;
            default: uhz = `PRX_RATE_7_UHZ;
        endcase
        // each period rounds down, never below one cycle
        period_of = 32'((64'(CLK_HZ) * `PRX_UHZ_PER_HZ) / uhz);
        if (period_of == 32'h0000_0000) begin
            period_of = 32'h0000_0001;
        end
    endfunction

    wire  [31:0] period_now = period_of(applied_rate);

    // read mux; unmapped addresses return zero
    logic [7:0] next_rdata;
    always_comb begin
        case (reg_addr)
            `PRX_OFS_RATE:     next_rdata = {5'h00, rate_written};
            `PRX_OFS_CURRENT:  next_rdata = {CAL_TAG, led_current_code};
            `PRX_OFS_RES_HIGH: next_rdata = result[15:8];
            `PRX_OFS_RES_LOW:  next_rdata = low_byte;
            default:           next_rdata = 8'h00;
        endcase
    end

    // ==========================================
    // rate register and its deferred application
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rate_written <= `PRX_RATE_RESET;
            applied_rate <= prx_pkg::PRX_RATE_1P95;
        end else if (ce) begin
            if (wr_rate) begin
                rate_written <= reg_wdata[`PRX_RATE_MSB:0];
            end
            // held while self-timing runs, so a period is never cut short
            if (!selftimed_en) begin
                applied_rate <= prx_pkg::prx_rate_t'(rate_written);
            end
        end
    end

    // ==========================================
    // emitter current; upper bits have no storage and ignore writes
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            led_current_code <= `PRX_CUR_RESET;
        end else if (ce && wr_cur) begin
            led_current_code <= cur_sat;
        end
    end

    // ==========================================
    // self-timed measurement trigger at the applied rate
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tick_cnt  <= 32'h0000_0000;
            meas_tick <= 1'b0;
        end else if (ce) begin
            meas_tick <= 1'b0;
            if (!selftimed_en) begin
                tick_cnt <= 32'h0000_0000;
            end else if (tick_cnt == 32'h0000_0000) begin
                tick_cnt  <= period_now - 32'h0000_0001;
                meas_tick <= 1'b1;
            end else begin
                tick_cnt <= tick_cnt - 32'h0000_0001;
            end
        end
    end

    // ==========================================
    // result capture, burst shadow and read data
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            result       <= 16'h0000;
            low_shadow   <= 8'h00;
            shadow_armed <= 1'b0;
            reg_rdata    <= 8'h00;
        end else if (ce) begin
            if (meas_valid) begin
                result <= meas_result;
            end
            // freeze low byte so a high/low pair stays one measurement
            if (rd_high) begin
                low_shadow   <= result[7:0];
                shadow_armed <= 1'b1;
            end else if (rd_low) begin
                shadow_armed <= 1'b0;
            end
            if (reg_rd) begin
                reg_rdata <= next_rdata;
            end
        end
    end

    // ==========================================
    // checks
    sequence cur_write_s;
        ce && wr_cur;
    endsequence

    rate_reset_val_a: assert property (@(posedge clk)
        $rose(resetn) |-> applied_rate == prx_pkg::PRX_RATE_1P95)
        else $error("rate not at slowest code after reset");

    rate_hold_a: assert property (@(posedge clk) disable iff (!resetn)
        ce && selftimed_en && $past(selftimed_en) |=> $stable(applied_rate))
        else $error("applied rate changed while self-timing");

    rate_apply_a: assert property (@(posedge clk) disable iff (!resetn)
        ce && !selftimed_en |=> applied_rate == $past(rate_written))
        else $error("rate not applied while idle");

    cur_write_a: assert property (@(posedge clk) disable iff (!resetn)
        cur_write_s and reg_wdata[5:0] <= 6'h14 |=> led_current_code == $past(reg_wdata[5:0]))
        else $error("current code not stored");

    cur_sat_a: assert property (@(posedge clk) disable iff (!resetn)
        cur_write_s and reg_wdata[5:0] > 6'h14 |=> led_current_code == 6'h14)
        else $error("current code not saturated");

    cur_max_a: assert property (@(posedge clk) disable iff (!resetn)
        led_current_code <= 6'h14)
        else $error("current code above maximum");

    tag_ro_a: assert property (@(posedge clk) disable iff (!resetn)
        ce && reg_rd && reg_addr == 8'h83 |=> reg_rdata[7:6] == CAL_TAG)
        else $error("calibration tag altered");

    res_high_a: assert property (@(posedge clk) disable iff (!resetn)
        ce && meas_valid ##1 ce && reg_rd && reg_addr == 8'h87
        |=> reg_rdata == $past(meas_result[15:8], 2))
        else $error("result high byte wrong");

    burst_pair_a: assert property (@(posedge clk) disable iff (!resetn)
        ce && rd_high ##1 ce && rd_low |=> reg_rdata == $past(result[7:0], 2))
        else $error("low byte not from same measurement");

endmodule

/* shared/prx_map.svh */
// register offsets, field positions, reset values and timing figures
// assumes: included by bare name from the register block
`ifndef PRX_MAP_SVH
`define PRX_MAP_SVH

// ==========================================
// register offsets
`define PRX_OFS_RATE       8'h82
`define PRX_OFS_CURRENT    8'h83
`define PRX_OFS_RES_HIGH   8'h87
`define PRX_OFS_RES_LOW    8'h88

// ==========================================
// field positions and reset values
`define PRX_RATE_MSB       2
`define PRX_CUR_MSB        5
`define PRX_TAG_LSB        6
`define PRX_RATE_RESET     3'h0
`define PRX_CUR_RESET      6'h02
`define PRX_CUR_MAX        6'h14
`define PRX_CAL_TAG        2'h1

// ==========================================
// rates in micro-measurements per second, codes 0..7
`define PRX_RATE_0_UHZ     64'd1950000
`define PRX_RATE_1_UHZ     64'd3906250
`define PRX_RATE_2_UHZ     64'd7812500
`define PRX_RATE_3_UHZ     64'd16625000
`define PRX_RATE_4_UHZ     64'd31250000
`define PRX_RATE_5_UHZ     64'd62500000
`define PRX_RATE_6_UHZ     64'd125000000
`define PRX_RATE_7_UHZ     64'd250000000
`define PRX_UHZ_PER_HZ     64'd1000000
`define PRX_CLK_HZ         100000000

`endif

/* shared/prx_pkg.sv */
// types shared by the proximity register block
// assumes: offsets and figures live in prx_map.svh
package prx_pkg;

    // ==========================================
    // measurement rate codes
    typedef enum logic [2:0] {
        PRX_RATE_1P95  = 3'h0,
        PRX_RATE_3P9   = 3'h1,
        PRX_RATE_7P8   = 3'h2,
        PRX_RATE_16P6  = 3'h3,
        PRX_RATE_31P25 = 3'h4,
        PRX_RATE_62P5  = 3'h5,
        PRX_RATE_125   = 3'h6,
        PRX_RATE_250   = 3'h7
    } prx_rate_t;

endpackage

/* testbench/prx_host.sv */
// host model: issues one-cycle register strobes
// assumes: bench clock, strobes launched on the falling edge
`timescale 1ns/1ps
module prx_host (
    input  wire logic       clk,
    input  wire logic [7:0] reg_rdata,
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic      [7:0] reg_wdata,
    output logic            reg_rd
);
    // ==========================================
    // bus tasks
    initial begin
        reg_addr  = 8'h00;
        reg_wr    = 1'b0;
        reg_wdata = 8'h00;
        reg_rd    = 1'b0;
    end
    // idle lines show inverted values so a stale address never matches
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge clk);
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask
    // data is registered, so it is taken one falling edge after launch
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge clk);
        reg_rd   = 1'b0;
        reg_addr = ~a;
        d        = reg_rdata;
    endtask
endmodule

/* testbench/tb_prx_regs.sv */
// bench for the proximity register block
// assumes: host model drives the strobe bus, clock enable held high except during one write
`timescale 1ns/1ps
module tb_prx_regs;
    localparam logic [1:0] TAG = 2'h2; // value arbitrary
    logic        clk, resetn, selftimed_en, meas_valid, meas_tick, reg_wr, reg_rd;
    logic        ce;           // clock enable, dropped once to see state freeze
    logic [15:0] meas_result;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
    logic [5:0]  led_current_code;
    prx_pkg::prx_rate_t applied_rate;
    int          n_mismatch, cmp_count, n;
    logic [7:0]  wv [4] = '{8'h00, 8'h14, 8'h15, 8'hff}; // current writes
    logic [5:0]  ev [4] = '{6'h00, 6'h14, 6'h14, 6'h14}; // codes expected

    prx_host u_host (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd));
    // small clock figure: rate code 7 gives a 40-cycle tick period
    prx_regs #(.CLK_HZ(10000), .CAL_TAG(TAG)) u_dut (.clk(clk), .resetn(resetn),
        .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .selftimed_en(selftimed_en),
        .meas_valid(meas_valid), .meas_result(meas_result),
        .applied_rate(applied_rate), .meas_tick(meas_tick),
        .led_current_code(led_current_code));

    // ==========================================
    // clock, checks and closing
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // bounded wait for the next tick, counting falling edges
    task automatic wait_tick;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (meas_tick !== 1'b1 && n < 100);
    endtask
    // watchdog well beyond the expected run of about 130 cycles
    initial begin
        #50000;
        n_mismatch++;
        test_done();
    end

    // ==========================================
    // main sequence
    initial begin
        resetn = 1'b0;
        ce = 1'b1;
        selftimed_en = 1'b0;
        meas_valid = 1'b0;
        meas_result = 16'h0000;
        repeat (5) @(negedge clk);
        resetn = 1'b1;
        u_host.rd(8'h82, d);
        check(d, 8'h00);
        check({5'h00, applied_rate}, 8'h00);
        u_host.rd(8'h83, d);
        check(d, {TAG, 6'h02});
        $display("test reset values done");
        // tag bits must survive an all-ones write
        for (int i = 0; i < 4; i++) begin
            u_host.wr(8'h83, wv[i]);
            u_host.rd(8'h83, d);
            check(d, {TAG, ev[i]});
            check({2'h0, led_current_code}, {2'h0, ev[i]});
        end
        // a write while the clock enable is low must leave the code alone
        ce = 1'b0;
        u_host.wr(8'h83, 8'h05);
        check({2'h0, led_current_code}, 8'h14);
        ce = 1'b1;
        u_host.rd(8'h83, d);
        check(d, {TAG, 6'h14});
        $display("test emitter current done");
        // upper rate bits are set to see them dropped
        for (int i = 0; i < 8; i++) begin
            u_host.wr(8'h82, {5'h1f, i[2:0]});
            @(negedge clk);
            check({5'h00, applied_rate}, {5'h00, i[2:0]});
            u_host.rd(8'h82, d);
            check(d, {5'h00, i[2:0]});
        end
        $display("test rate codes done");
        selftimed_en = 1'b1;
        wait_tick();
        check(n[7:0], 8'h01);
        wait_tick();
        check(n[7:0], 8'd40);
        u_host.wr(8'h82, 8'h03);
        repeat (3) @(negedge clk);
        check({5'h00, applied_rate}, 8'h07);
        selftimed_en = 1'b0;
        @(negedge clk);
        check({5'h00, applied_rate}, 8'h03);
        $display("test deferred rate done");
        meas_result = 16'ha55a;
        meas_valid = 1'b1;
        @(negedge clk);
        meas_valid = 1'b0;
        meas_result = 16'h5aa5;
        u_host.wr(8'h87, 8'h00);
        u_host.rd(8'h87, d);
        check(d, 8'ha5);
        meas_result = 16'h1234;
        meas_valid = 1'b1;
        @(negedge clk);
        meas_valid = 1'b0;
        meas_result = 16'hedcb;
        u_host.rd(8'h88, d);
        check(d, 8'h5a);
        u_host.rd(8'h88, d);
        check(d, 8'h34);
        u_host.rd(8'h90, d);
        check(d, 8'h00);
        $display("test result bytes done");
        test_done();
    end
endmodule
